// ==== common/rdbf_pkg.sv ====
// Purpose: constants and types shared by the radiometer data block formatter
// Assumes: one 40 MHz system clock
// Notes: block layout, bit timing and calibration timing live here
package rdbf_pkg;

  // ----------------------------------------------------------------
  // clock and serial timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned BIT_RATE_BPS = 40_000;
  localparam int unsigned BIT_CYC = CLK_HZ / BIT_RATE_BPS;
  localparam int unsigned BIT_CNT_W = 10;

  // ----------------------------------------------------------------
  // block layout
  // ----------------------------------------------------------------
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned SAMPLE_BITS = 13;
  localparam int unsigned SAMPLE_LEVELS = 8192;
  localparam int unsigned BLOCK_WORDS = 250;
  localparam logic [7:0] IDX_SYNC0 = 8'h00;
  localparam logic [7:0] IDX_SYNC1 = 8'h01;
  localparam logic [7:0] IDX_HEADER = 8'h02;
  localparam logic [7:0] IDX_SCAN_POS = 8'h03;
  localparam logic [7:0] IDX_ATTITUDE = 8'h04;
  localparam logic [7:0] IDX_SCAN_CTL = 8'h05;
  localparam logic [7:0] IDX_TLM = 8'h06;
  localparam logic [7:0] IDX_LAST = 8'hf9;
  localparam logic [15:0] SYNC_WORD0 = 16'hfaf3;
  localparam logic [15:0] SYNC_WORD1 = 16'h20c4;
  localparam logic [15:0] FILL_WORD = 16'h0000;
  localparam logic [3:0] BIT_MSB = 4'hf;

  // ----------------------------------------------------------------
  // frame schedule and calibration
  // ----------------------------------------------------------------
  localparam logic [15:0] FRAME_BLOCKS = 16'h0258;
  localparam logic [15:0] SPACE_LOOK_BLK = 16'h0000;
  localparam int unsigned SPACE_LOOK_MS = 200;
  localparam int unsigned SPACE_LOOK_CYC = (CLK_HZ / 1000) * SPACE_LOOK_MS;
  localparam int unsigned CAL_LEVELS = 16;
  localparam int unsigned CAL_DWELL_CYC = SPACE_LOOK_CYC / CAL_LEVELS;
  localparam logic [3:0] CAL_LAST_LVL = 4'hf;
  localparam logic [9:0] CAL_STEP = 10'h040;
  localparam logic [9:0] CAL_IDLE_CODE = 10'h000;

  // ----------------------------------------------------------------
  // buffering
  // ----------------------------------------------------------------
  localparam int unsigned FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] tlm;
    logic [15:0] scan_pos;
    logic [15:0] attitude;
    logic [15:0] scan_ctl;
  } rdbf_aux_t;

  typedef enum logic [1:0] {
    FMT_IDLE = 2'b00,
    FMT_RUN = 2'b01
  } rdbf_fmt_state_t;

  typedef enum logic [1:0] {
    CAL_OFF = 2'b00,
    CAL_RUN = 2'b01
  } rdbf_cal_state_t;

endpackage : rdbf_pkg

// ==== core/rdbf_formatter.sv ====
// Purpose: data block formatter with sample buffer and calibration sequencer
// Assumes: samples and aux words come from logic on CLK_SYS; FW_REV is a pin
// Notes: one block per revolution pulse, 250 words unless the next pulse restarts it; serial msb first
`timescale 1ns/1ps

// ------------------------------------------------------------------
// sample buffer
// ------------------------------------------------------------------
module rdbf_fifo #(
  parameter int unsigned W = 13,
  parameter int unsigned D = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic in_rdy_r;
  wire push = in_valid && in_rdy_r;
  wire pop = out_ready && (cnt_r != '0);

  assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready = in_rdy_r;
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
      in_rdy_r <= 1'b0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(D-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(D-1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      in_rdy_r <= (cnt_nxt != (AW+1)'(D));
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  fifo_full_a: assert property (@(posedge clk) disable iff (!arst_n)
    (cnt_r == (AW+1)'(D)) |-> !in_ready)
    else $error("buffer accepts while full");

endmodule : rdbf_fifo

// ------------------------------------------------------------------
// formatter top
// ------------------------------------------------------------------
module rdbf_formatter import rdbf_pkg::*; #(
  parameter int unsigned CAL_DWELL = CAL_DWELL_CYC
) (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic FW_REV,
  input wire logic SAMPLE_STB,
  input wire logic [SAMPLE_BITS-1:0] SAMPLE_CODE,
  output logic SAMPLE_READY,
  input wire rdbf_aux_t AUX_WORDS,
  output logic SER_DATA,
  output logic SER_BIT_TICK,
  output logic SER_GATE,
  output logic [9:0] CAL_CODE,
  output logic CAL_ACTIVE
);

  // ----------------------------------------------------------------
  // revolution pulse synchroniser
  // ----------------------------------------------------------------
  logic rev_s1_r;
  logic rev_s2_r;
  logic rev_s3_r;
  logic rev_lvl_r;
  wire rev_agree = (rev_s2_r == rev_s3_r);
  wire rev_evt = rev_agree && rev_s2_r && !rev_lvl_r;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rev_s1_r <= 1'b0;
      rev_s2_r <= 1'b0;
      rev_s3_r <= 1'b0;
      rev_lvl_r <= 1'b0;
    end else begin
      rev_s1_r <= FW_REV;
      rev_s2_r <= rev_s1_r;
      rev_s3_r <= rev_s2_r;
      if (rev_agree) begin
        rev_lvl_r <= rev_s2_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // sample buffer on the shared bus
  // ----------------------------------------------------------------
  logic fifo_valid;
  logic [SAMPLE_BITS-1:0] fifo_code;
  logic fifo_pop;

  rdbf_fifo #(.W(SAMPLE_BITS), .D(FIFO_DEPTH)) u_buf (
    .clk(CLK_SYS),
    .arst_n(ARST_N),
    .in_valid(SAMPLE_STB),
    .in_ready(SAMPLE_READY),
    .in_data(SAMPLE_CODE),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_code)
  );

  // ----------------------------------------------------------------
  // bit, word and block timing
  // ----------------------------------------------------------------
  rdbf_fmt_state_t fmt_r;
  logic [BIT_CNT_W-1:0] bit_cyc_r;
  logic [3:0] bit_idx_r;
  logic [7:0] word_idx_r;
  logic [15:0] blk_r;
  logic [15:0] shift_r;
  logic ser_r;
  logic tick_r;

  wire running = (fmt_r == FMT_RUN);
  wire bit_evt = running && (bit_cyc_r == BIT_CNT_W'(BIT_CYC - 1));
  wire word_end = bit_evt && (bit_idx_r == BIT_MSB);
  wire block_end = word_end && (word_idx_r == IDX_LAST);
  wire word_load = rev_evt || (word_end && !block_end);
  wire [7:0] load_idx = rev_evt ? IDX_SYNC0 : word_idx_r + 8'h01;
  wire [15:0] blk_nxt = (blk_r == FRAME_BLOCKS - 16'h0001) ? 16'h0000 : blk_r + 16'h0001;

  // ----------------------------------------------------------------
  // fixed layout word select
  // ----------------------------------------------------------------
  function automatic logic is_sample_slot(input logic [7:0] idx);
    return idx > IDX_TLM;
  endfunction : is_sample_slot

  logic cal_on;
  wire load_sample = is_sample_slot(load_idx);
  // blk_r already holds this block's number once the header slot loads
  wire [15:0] header_word = {cal_on, blk_r[14:0]};
  wire [15:0] sample_word = fifo_valid ? {3'b000, fifo_code} : FILL_WORD;
  wire [15:0] word_sel =
    (load_idx == IDX_SYNC0) ? SYNC_WORD0 :
    (load_idx == IDX_SYNC1) ? SYNC_WORD1 :
    (load_idx == IDX_HEADER) ? header_word :
    (load_idx == IDX_SCAN_POS) ? AUX_WORDS.scan_pos :
    (load_idx == IDX_ATTITUDE) ? AUX_WORDS.attitude :
    (load_idx == IDX_SCAN_CTL) ? AUX_WORDS.scan_ctl :
    (load_idx == IDX_TLM) ? AUX_WORDS.tlm : sample_word;

  assign fifo_pop = word_load && load_sample;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      fmt_r <= FMT_IDLE;
      bit_cyc_r <= '0;
      bit_idx_r <= '0;
      word_idx_r <= '0;
      blk_r <= FRAME_BLOCKS - 16'h0001;
    end else begin
      case (fmt_r)
        FMT_IDLE: begin
          if (rev_evt) begin
            fmt_r <= FMT_RUN;
          end
        end
        FMT_RUN: begin
          if (block_end && !rev_evt) begin
            fmt_r <= FMT_IDLE;
          end
        end
        default: fmt_r <= FMT_IDLE;
      endcase
      if (rev_evt) begin
        blk_r <= blk_nxt;
      end
      if (rev_evt || bit_evt) begin
        bit_cyc_r <= '0;
      end else if (running) begin
        bit_cyc_r <= bit_cyc_r + 1'b1;
      end
      if (word_load) begin
        bit_idx_r <= '0;
        word_idx_r <= load_idx;
      end else if (bit_evt) begin
        bit_idx_r <= bit_idx_r + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // serialiser, msb first
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      shift_r <= '0;
      ser_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= word_load || (bit_evt && !block_end);
      if (word_load) begin
        shift_r <= word_sel;
        ser_r <= word_sel[15];
      end else if (bit_evt && !block_end) begin
        shift_r <= {shift_r[14:0], 1'b0};
        ser_r <= shift_r[14];
      end else if (block_end) begin
        ser_r <= 1'b0;
      end
    end
  end

  assign SER_DATA = ser_r;
  assign SER_BIT_TICK = tick_r;
  assign SER_GATE = (fmt_r == FMT_RUN);

  // ----------------------------------------------------------------
  // calibration sequencer
  // ----------------------------------------------------------------
  rdbf_cal_state_t cal_r;
  logic [3:0] lvl_r;
  logic [23:0] dwell_r;
  logic [9:0] code_r;
  // number of the block being opened, so the first block after reset is 0
  wire cal_go = rev_evt && (blk_nxt == SPACE_LOOK_BLK);
  wire dwell_end = (cal_r == CAL_RUN) && (dwell_r == 24'(CAL_DWELL - 1));
  wire cal_last = dwell_end && (lvl_r == CAL_LAST_LVL);

  function automatic logic [9:0] lvl_code(input logic [3:0] lvl);
    return 10'(lvl * CAL_STEP);
  endfunction : lvl_code

  assign cal_on = (cal_r == CAL_RUN) && !cal_last;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      cal_r <= CAL_OFF;
      lvl_r <= '0;
      dwell_r <= '0;
      code_r <= CAL_IDLE_CODE;
    end else begin
      case (cal_r)
        CAL_OFF: begin
          if (cal_go) begin
            cal_r <= CAL_RUN;
            lvl_r <= '0;
            dwell_r <= '0;
            code_r <= lvl_code(4'h0);
          end
        end
        CAL_RUN: begin
          if (cal_last) begin
            cal_r <= CAL_OFF;
            code_r <= CAL_IDLE_CODE;
          end else if (dwell_end) begin
            dwell_r <= '0;
            lvl_r <= lvl_r + 1'b1;
            code_r <= lvl_code(lvl_r + 1'b1);
          end else begin
            dwell_r <= dwell_r + 1'b1;
          end
        end
        default: cal_r <= CAL_OFF;
      endcase
    end
  end

  assign CAL_CODE = code_r;
  assign CAL_ACTIVE = (cal_r == CAL_RUN);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [BIT_CNT_W-1:0] gap_r;
  logic [8:0] words_r;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      gap_r <= '0;
      words_r <= '0;
    end else begin
      gap_r <= tick_r ? '0 : gap_r + 1'b1;
      if (rev_evt) begin
        words_r <= 9'h001;
      end else if (word_load) begin
        words_r <= words_r + 1'b1;
      end
    end
  end

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  sample_pad_a: assert property (word_load && load_sample |=> shift_r[15:13] == 3'b000)
    else $error("sample word upper bits not clear");
  sync_slot_a: assert property (rev_evt |=> shift_r == SYNC_WORD0 && word_idx_r == '0)
    else $error("block does not open with sync word");
  rev_align_a: assert property (rev_evt |=> SER_GATE && SER_BIT_TICK && bit_cyc_r == '0)
    else $error("block not aligned to revolution");
  block_len_a: assert property (block_end |-> words_r == 9'h0fa)
    else $error("block word count wrong");
  bit_period_a: assert property (tick_r && SER_GATE && gap_r != '0 && !$past(rev_evt)
    |-> gap_r == BIT_CNT_W'(BIT_CYC - 1))
    else $error("bit period wrong");
  msb_first_a: assert property (word_load |=> SER_DATA == $past(word_sel[15]))
    else $error("word not sent msb first");
  cal_start_a: assert property (cal_go && !CAL_ACTIVE |=> CAL_ACTIVE && CAL_CODE == '0)
    else $error("space look not started on schedule");
  cal_ascend_a: assert property (dwell_end && !cal_last
    |=> CAL_CODE == $past(CAL_CODE) + CAL_STEP)
    else $error("calibration level not ascending");
  cal_dwell_a: assert property ($changed(lvl_r) && CAL_ACTIVE
    |-> $past(dwell_r) == 24'(CAL_DWELL - 1))
    else $error("calibration dwell wrong");

  full_block_c: cover property (block_end);
  cal_done_c: cover property (cal_last);
  fill_used_c: cover property (word_load && load_sample && !fifo_valid);
  backpress_c: cover property (SAMPLE_STB && !SAMPLE_READY);

endmodule : rdbf_formatter

// ==== tb/rdbf_tb_sink.sv ====
// Purpose: model of the sensor data transmitter taking the serial block stream
// Assumes: bits sampled on the tick cycle, words msb first
// Notes: reports each word and the cycle gap between the last two ticks
`timescale 1ns/1ps

// ------------------------------------------------------------------
// serial receiver
// ------------------------------------------------------------------
module rdbf_tb_sink (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ser_data,
  input wire logic ser_tick,
  input wire logic ser_gate,
  output logic [15:0] word_r,
  output logic word_stb_r,
  output logic [15:0] gap_r
);
  logic [15:0] shift_r;
  logic [3:0] nbit_r;
  logic [15:0] cnt_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_r <= 16'h0000;
      nbit_r <= 4'h0;
      cnt_r <= 16'h0000;
      word_r <= 16'h0000;
      word_stb_r <= 1'b0;
      gap_r <= 16'h0000;
    end else begin
      word_stb_r <= 1'b0;
      cnt_r <= cnt_r + 16'h0001;
      if (!ser_gate) begin
        nbit_r <= 4'h0;
      end else if (ser_tick) begin
        gap_r <= cnt_r;
        cnt_r <= 16'h0001;
        shift_r <= {shift_r[14:0], ser_data};
        nbit_r <= nbit_r + 4'h1;
        if (nbit_r == 4'hf) begin
          word_r <= {shift_r[14:0], ser_data};
          word_stb_r <= 1'b1;
        end
      end
    end
  end
endmodule : rdbf_tb_sink

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench for the radiometer data block formatter
// Assumes: short calibration dwell; blocks are cut short by early revolutions
// Notes: random sample codes and aux words from a fixed seed
`timescale 1ns/1ps
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("mismatch at %0t: %s", $time, m); end end

module tb_top import rdbf_pkg::*; ;
  localparam int unsigned DWELL = 20;
  logic clk_sys;
  logic arst_n;
  logic fw_rev;
  logic sample_stb;
  logic [SAMPLE_BITS-1:0] sample_code;
  logic sample_ready;
  rdbf_aux_t aux_words;
  logic ser_data;
  logic ser_bit_tick;
  logic ser_gate;
  logic [9:0] cal_code;
  logic cal_active;
  logic [15:0] word;
  logic word_stb;
  logic [15:0] gap;
  int seed;
  int n_fail;
  int checked;

  rdbf_formatter #(.CAL_DWELL(DWELL)) i_rdbf_formatter (.CLK_SYS(clk_sys), .ARST_N(arst_n),
    .FW_REV(fw_rev), .SAMPLE_STB(sample_stb), .SAMPLE_CODE(sample_code),
    .SAMPLE_READY(sample_ready), .AUX_WORDS(aux_words), .SER_DATA(ser_data),
    .SER_BIT_TICK(ser_bit_tick), .SER_GATE(ser_gate), .CAL_CODE(cal_code),
    .CAL_ACTIVE(cal_active));
  rdbf_tb_sink i_rdbf_tb_sink (.clk(clk_sys), .arst_n(arst_n), .ser_data(ser_data),
    .ser_tick(ser_bit_tick), .ser_gate(ser_gate), .word_r(word), .word_stb_r(word_stb),
    .gap_r(gap));

  initial clk_sys = 1'b0;
  always #12.5 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [9:0] cal_exp(input int l);
    return 10'(l) * CAL_STEP;
  endfunction : cal_exp

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  // use_cal picks cal_active, otherwise the sink's word strobe
  task automatic wait_hi(input bit use_cal, input int lim);
    int i;
    i = 0;
    @(posedge clk_sys);
    #1;
    while ((use_cal ? cal_active : word_stb) !== 1'b1 && i < lim) begin
      @(posedge clk_sys);
      #1;
      i++;
    end
    if ((use_cal ? cal_active : word_stb) !== 1'b1) begin
      n_fail++;
      $display("mismatch at %0t: wait timed out", $time);
      summarize();
    end
  endtask : wait_hi

  task automatic get_word(input logic [15:0] exp);
    wait_hi(1'b0, 20000);
    `CHK(word, exp, "word value")
    `CHK(gap, 16'(BIT_CYC), "bit period")
    `CHK(ser_gate, 1'b1, "gate during block")
  endtask : get_word

  task automatic fill();
    int taken;
    logic rdy;
    taken = 0;
    @(posedge clk_sys);
    @(posedge clk_sys);
    sample_stb <= 1'b1;
    sample_code <= 13'($random(seed));
    #1 rdy = sample_ready;
    repeat (16) begin
      @(posedge clk_sys);
      if (rdy) begin
        taken++;
        sample_code <= 13'($random(seed));
      end
      #1 rdy = sample_ready;
    end
    `CHK(taken, 8, "buffer entries")
    `CHK(sample_ready, 1'b0, "buffer full")
    @(posedge clk_sys);
    sample_stb <= 1'b0;
  endtask : fill

  task automatic check_cal();
    wait_hi(1'b1, 20);
    `CHK(cal_code, 10'h000, "first level")
    repeat (DWELL / 2) @(posedge clk_sys);
    for (int l = 0; l < 16; l++) begin
      #1 `CHK(cal_code, cal_exp(l), "cal level")
      `CHK(cal_active, 1'b1, "space look")
      repeat (DWELL) @(posedge clk_sys);
    end
    #1 `CHK(cal_active, 1'b0, "space look end")
    `CHK(cal_code, CAL_IDLE_CODE, "idle code")
  endtask : check_cal

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 22;
    n_fail = 0;
    checked = 0;
    arst_n = 1'b0;
    fw_rev = 1'b0;
    sample_stb = 1'b0;
    sample_code = 13'h0000;
    aux_words = {$random(seed), $random(seed)};
    repeat (2) @(posedge clk_sys);
    #1 `CHK(ser_gate, 1'b0, "gate in reset")
    `CHK(cal_code, CAL_IDLE_CODE, "code in reset")
    `CHK(sample_ready, 1'b0, "ready in reset")
    @(posedge clk_sys);
    arst_n <= 1'b1;
    fill();
    @(posedge clk_sys);
    fw_rev <= 1'b1;
    check_cal();
    @(posedge clk_sys);
    fw_rev <= 1'b0;
    get_word(SYNC_WORD0);
    get_word(SYNC_WORD1);
    @(posedge clk_sys);
    fw_rev <= 1'b1;
    repeat (20) @(posedge clk_sys);
    #1 `CHK(cal_active, 1'b0, "no second space look")
    get_word(SYNC_WORD0);
    get_word(SYNC_WORD1);
    get_word(16'h0001);
    get_word(aux_words.scan_pos);
    summarize();
  end
endmodule : tb_top
